/* verilog/uart_control_flow_loopback.sv */
// port control, flow control, section enables and loopback of a serial port
// assumes a synchronous host on the register port and pins synchronous to sys_clk
//
// Functional notes
// - reset clears control except both section enables
// - cts flow on: send only with cts low
// - rts flow on: request only with room
// - aux b pin is inverse of bit
// - aux a pin is inverse of bit
// - request-send pin is inverse of bit
// - terminal-ready pin is inverse of bit
// - receive enable starts receiver, pin per ir
// - transmit enable starts transmitter, pin per ir
// - receive disable finishes current character first
// - transmit disable finishes current character first
// - ir loopback inverts ir out into ir in
// - plain loopback feeds tx into rx
// - loopback also feeds modem outputs to inputs
// - sections need port enable too
// - ir mode holds plain tx pin high
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "port_ctl_regs.svh"
module uart_control_flow_loopback #(
	parameter logic [15:0] BIT_CYCLES = `PC_BIT_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rdata,
	// transmit stream in
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// receive stream out
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	// serial and infrared pins
	output logic serial_tx_pin,
	input wire logic serial_rx_pin,
	output logic ir_pulse_pin_n,
	input wire logic ir_receive_pin,
	// modem outputs
	output logic request_send_pin_n,
	output logic terminal_ready_pin_n,
	output logic aux_output_a_pin_n,
	output logic aux_output_b_pin_n,
	// modem inputs
	input wire logic clear_to_send_pin_n,
	input wire logic data_set_ready_pin_n,
	input wire logic carrier_detect_pin_n,
	input wire logic ring_pin_n
);
	// ----------------------------------------
	// state and decode helpers
	// ----------------------------------------
	port_ctl_pkg::state_t s_reg; // all state
	port_ctl_pkg::state_t s_next; // its next value
	logic port_en; // port enable bit
	logic tx_go; // transmitter may start a character
	logic rx_go; // receiver may start a character
	logic cts_eff_n; // clear-to-send after loopback
	logic dsr_eff_n; // data-set-ready after loopback
	logic dcd_eff_n; // carrier after loopback
	logic ri_eff_n; // ring after loopback
	logic rx_line; // selected receive line
	logic room; // receive buffer can take a character
	logic tx_tick; // end of a transmit bit time
	logic rx_tick; // end of a receive bit or half bit
	logic tx_pop; // character leaves the transmit buffer
	logic rx_push; // character enters the receive buffer

	// address match, used by both read and write decode
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction : hit

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.rdata = 16'h0000;
		port_en = s_reg.ctl[`PC_PORT_EN];
		// modem inputs come from our own outputs in loopback
		if (s_reg.ctl[`PC_LOOP]) begin
			cts_eff_n = s_reg.pins.rts_n;
			dsr_eff_n = s_reg.pins.dtr_n;
			dcd_eff_n = s_reg.pins.aux_a_n;
			ri_eff_n = s_reg.pins.aux_b_n;
		end else begin
			cts_eff_n = clear_to_send_pin_n;
			dsr_eff_n = data_set_ready_pin_n;
			dcd_eff_n = carrier_detect_pin_n;
			ri_eff_n = ring_pin_n;
		end
		// receive line select
		if (s_reg.ctl[`PC_LOOP] && s_reg.ctl[`PC_IR_EN] && s_reg.tst) begin
			rx_line = ~s_reg.pins.ir_n;
		end else if (s_reg.ctl[`PC_LOOP] && !s_reg.tst) begin
			rx_line = s_reg.tx_line;
		end else if (s_reg.ctl[`PC_IR_EN]) begin
			rx_line = ir_receive_pin;
		end else begin
			rx_line = serial_rx_pin;
		end
		// start permissions; a running character is never cut short
		tx_go = port_en && s_reg.ctl[`PC_TX_EN]
			&& (!s_reg.ctl[`PC_CTS_FLOW] || !cts_eff_n);
		rx_go = port_en && s_reg.ctl[`PC_RX_EN];
		room = (s_reg.rx_cnt != 2'h2);
		tx_tick = (s_reg.tx_div == BIT_CYCLES - 16'h1);
		if (s_reg.rx_ph == port_ctl_pkg::PH_START) begin
			rx_tick = (s_reg.rx_div == (BIT_CYCLES >> 1) - 16'h1);
		end else begin
			rx_tick = (s_reg.rx_div == BIT_CYCLES - 16'h1);
		end
		tx_pop = (s_reg.tx_ph == port_ctl_pkg::PH_IDLE) && tx_go && (s_reg.tx_cnt != 2'h0);
		rx_push = (s_reg.rx_ph == port_ctl_pkg::PH_STOP) && rx_tick && rx_line && room;

		// register writes
		if (wr_en) begin
			if (hit(addr, `PC_CTL_OFF)) begin
				s_next.ctl = wdata & `PC_CTL_MASK;
			end else if (hit(addr, `PC_TST_OFF)) begin
				s_next.tst = wdata[`PC_IR_TEST];
			end
		end
		// register reads, data stands the next cycle only
		if (rd_en) begin
			if (hit(addr, `PC_CTL_OFF)) begin
				s_next.rdata = s_reg.ctl;
			end else if (hit(addr, `PC_TST_OFF)) begin
				s_next.rdata[`PC_IR_TEST] = s_reg.tst;
			end else if (hit(addr, `PC_STA_OFF)) begin
				s_next.rdata[7:0] = {~ri_eff_n, ~dcd_eff_n, ~dsr_eff_n, ~cts_eff_n,
					!room, !s_reg.tx_in_ready,
					s_reg.rx_ph != port_ctl_pkg::PH_IDLE,
					s_reg.tx_ph != port_ctl_pkg::PH_IDLE};
			end
		end

		// transmit buffer: pop first, then push behind it
		if (tx_pop) begin
			s_next.txb[0] = s_reg.txb[1];
			s_next.tx_cnt = s_reg.tx_cnt - 2'h1;
		end
		if (tx_valid && s_reg.tx_in_ready) begin
			s_next.txb[s_next.tx_cnt[0]] = tx_data;
			s_next.tx_cnt = s_next.tx_cnt + 2'h1;
		end
		s_next.tx_in_ready = (s_next.tx_cnt != 2'h2);

		// transmitter, 8 data bits, one stop bit
		s_next.tx_div = tx_tick ? 16'h0000 : s_reg.tx_div + 16'h1;
		case (s_reg.tx_ph)
			port_ctl_pkg::PH_IDLE: begin
				s_next.tx_div = 16'h0000;
				if (tx_pop) begin
					s_next.tx_sh = s_reg.txb[0];
					s_next.tx_ph = port_ctl_pkg::PH_START;
				end
			end
			port_ctl_pkg::PH_START: begin
				if (tx_tick) begin
					s_next.tx_bit = 3'h0;
					s_next.tx_ph = port_ctl_pkg::PH_DATA;
				end
			end
			port_ctl_pkg::PH_DATA: begin
				// enables are not looked at here, so the character completes
				if (tx_tick) begin
					s_next.tx_bit = s_reg.tx_bit + 3'h1;
					if (s_reg.tx_bit == 3'h7) begin
						s_next.tx_ph = port_ctl_pkg::PH_STOP;
					end
				end
			end
			port_ctl_pkg::PH_STOP: begin
				if (tx_tick) begin
					s_next.tx_ph = port_ctl_pkg::PH_IDLE;
				end
			end
			default: begin
				s_next.tx_ph = port_ctl_pkg::PH_IDLE;
			end
		endcase
		// line level follows the next phase
		case (s_next.tx_ph)
			port_ctl_pkg::PH_START: s_next.tx_line = 1'b0;
			port_ctl_pkg::PH_DATA: s_next.tx_line = s_next.tx_sh[s_next.tx_bit];
			default: s_next.tx_line = 1'b1;
		endcase

		// receiver, samples mid bit
		s_next.rx_div = rx_tick ? 16'h0000 : s_reg.rx_div + 16'h1;
		case (s_reg.rx_ph)
			port_ctl_pkg::PH_IDLE: begin
				s_next.rx_div = 16'h0000;
				if (rx_go && !rx_line) begin
					s_next.rx_ph = port_ctl_pkg::PH_START;
				end
			end
			port_ctl_pkg::PH_START: begin
				// a glitch shorter than half a bit is not a start bit
				if (rx_tick) begin
					s_next.rx_bit = 3'h0;
					s_next.rx_ph = rx_line ? port_ctl_pkg::PH_IDLE : port_ctl_pkg::PH_DATA;
				end
			end
			port_ctl_pkg::PH_DATA: begin
				if (rx_tick) begin
					s_next.rx_sh[s_reg.rx_bit] = rx_line;
					s_next.rx_bit = s_reg.rx_bit + 3'h1;
					if (s_reg.rx_bit == 3'h7) begin
						s_next.rx_ph = port_ctl_pkg::PH_STOP;
					end
				end
			end
			port_ctl_pkg::PH_STOP: begin
				// a bad stop bit or a full buffer drops the character
				if (rx_tick) begin
					s_next.rx_ph = port_ctl_pkg::PH_IDLE;
				end
			end
			default: begin
				s_next.rx_ph = port_ctl_pkg::PH_IDLE;
			end
		endcase

		// receive buffer
		if (rx_ready && s_reg.rx_out_valid) begin
			s_next.rxb[0] = s_reg.rxb[1];
			s_next.rx_cnt = s_reg.rx_cnt - 2'h1;
		end
		if (rx_push) begin
			s_next.rxb[s_next.rx_cnt[0]] = s_reg.rx_sh;
			s_next.rx_cnt = s_next.rx_cnt + 2'h1;
		end
		s_next.rx_out_valid = (s_next.rx_cnt != 2'h0);

		// pins, registered from the current control value, or from room for rts flow
		s_next.pins.aux_b_n = ~s_reg.ctl[`PC_AUX_B];
		s_next.pins.aux_a_n = ~s_reg.ctl[`PC_AUX_A];
		s_next.pins.dtr_n = ~s_reg.ctl[`PC_TERM_RDY];
		if (s_reg.ctl[`PC_RTS_FLOW]) begin
			s_next.pins.rts_n = ~room;
		end else begin
			s_next.pins.rts_n = ~s_reg.ctl[`PC_REQ_SEND];
		end
		// ir mode marks the plain pin; ir out stays dark when unused
		s_next.pins.txd = s_reg.ctl[`PC_IR_EN] ? 1'b1 : s_reg.tx_line;
		s_next.pins.ir_n = (port_en && s_reg.ctl[`PC_IR_EN]) ? ~s_reg.tx_line : 1'b0;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_reg <= '0;
			s_reg.ctl <= `PC_CTL_RST;
			s_reg.tx_in_ready <= 1'b1;
			s_reg.tx_line <= 1'b1;
			s_reg.pins <= '{txd: 1'b1, ir_n: 1'b0, rts_n: 1'b1, dtr_n: 1'b1,
				aux_a_n: 1'b1, aux_b_n: 1'b1};
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state register
	assign rdata = s_reg.rdata;
	assign tx_ready = s_reg.tx_in_ready;
	assign rx_data = s_reg.rxb[0];
	assign rx_valid = s_reg.rx_out_valid;
	assign serial_tx_pin = s_reg.pins.txd;
	assign ir_pulse_pin_n = s_reg.pins.ir_n;
	assign request_send_pin_n = s_reg.pins.rts_n;
	assign terminal_ready_pin_n = s_reg.pins.dtr_n;
	assign aux_output_a_pin_n = s_reg.pins.aux_a_n;
	assign aux_output_b_pin_n = s_reg.pins.aux_b_n;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// sequences mark the idle-to-start step of each character
	sequence tx_starts;
		s_reg.tx_ph == port_ctl_pkg::PH_IDLE ##1 s_reg.tx_ph == port_ctl_pkg::PH_START;
	endsequence
	sequence rx_starts;
		s_reg.rx_ph == port_ctl_pkg::PH_IDLE ##1 s_reg.rx_ph == port_ctl_pkg::PH_START;
	endsequence

	// reset check keeps running through reset so it sees the release edge
	a_reset_value: assert property (disable iff (1'b0) $past(srst) |->
		s_reg.ctl == 16'h0300) else $error("control reset value wrong");
	a_cts_gate: assert property (tx_starts |-> $past(port_en)
		&& $past(!s_reg.ctl[15] || !cts_eff_n)) else $error("sent without clear-to-send");
	a_rts_room: assert property (s_reg.ctl[14] && s_reg.rx_cnt == 2'h2 |=>
		request_send_pin_n) else $error("request asserted with full buffer");
	a_aux_b_pin: assert property (##1 aux_output_b_pin_n ==
		!$past(s_reg.ctl[13])) else $error("aux b pin not inverted");
	a_aux_a_pin: assert property (s_reg.ctl[12] ##1 s_reg.ctl[12] |->
		!aux_output_a_pin_n) else $error("aux a pin not low");
	a_req_pin: assert property (!s_reg.ctl[14] && s_reg.ctl[11] |=>
		!request_send_pin_n) else $error("request pin not low");
	a_term_pin: assert property ($rose(s_reg.ctl[10]) |=>
		!terminal_ready_pin_n) else $error("terminal ready pin not low");
	a_rx_gate: assert property (rx_starts |-> $past(s_reg.ctl[9])
		&& $past(port_en)) else $error("receiver started while disabled");
	a_rx_finish: assert property (s_reg.rx_ph == port_ctl_pkg::PH_DATA |=>
		s_reg.rx_ph inside {port_ctl_pkg::PH_DATA, port_ctl_pkg::PH_STOP})
		else $error("reception cut short");
	a_tx_finish: assert property (s_reg.tx_ph == port_ctl_pkg::PH_DATA
		&& s_reg.tx_bit == 3'h0 |-> ##1 (s_reg.tx_ph == port_ctl_pkg::PH_DATA)[*7])
		else $error("transmission cut short");
	// the ir pin is registered, so the looped line trails the internal line by one
	// cycle; compare against the line itself rather than the pin that feeds it
	a_ir_loop: assert property (s_reg.ctl[7] && s_reg.ctl[1] && s_reg.tst
		&& $past(port_en && s_reg.ctl[1]) |-> rx_line == $past(s_reg.tx_line))
		else $error("ir loopback path wrong");
	a_plain_loop: assert property (s_reg.ctl[7] && !s_reg.tst |->
		rx_line == s_reg.tx_line) else $error("serial loopback path wrong");
	// modem loop compares against the pins the far side would see
	a_modem_loop: assert property (s_reg.ctl[7] |-> cts_eff_n == request_send_pin_n
		&& dsr_eff_n == terminal_ready_pin_n) else $error("modem loopback wrong");
	a_ir_mark: assert property (s_reg.ctl[1] |=> serial_tx_pin)
		else $error("plain pin not marking in ir mode");

endmodule : uart_control_flow_loopback

/* verilog/port_ctl_regs.svh */
// offsets, field positions, reset values and timing for the port control block
// assumes a 4-bit address on the plain register port, with registers four addresses apart
`ifndef PORT_CTL_REGS_SVH
`define PORT_CTL_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PC_CTL_OFF 4'h0
`define PC_TST_OFF 4'h4
`define PC_STA_OFF 4'h8
// ----------------------------------------
// port_control fields
// ----------------------------------------
`define PC_PORT_EN 0
`define PC_IR_EN 1
`define PC_LOOP 7
`define PC_TX_EN 8
`define PC_RX_EN 9
`define PC_TERM_RDY 10
`define PC_REQ_SEND 11
`define PC_AUX_A 12
`define PC_AUX_B 13
`define PC_RTS_FLOW 14
`define PC_CTS_FLOW 15
`define PC_CTL_RST 16'h0300
`define PC_CTL_MASK 16'hFF83
// ----------------------------------------
// test_control_reg fields, timing
// ----------------------------------------
`define PC_IR_TEST 2
`define PC_BIT_CYCLES 16'h0010
`endif

/* verilog/port_ctl_pkg.sv */
// types shared by the port control block
// assumes the constants header is included by users of these types
package port_ctl_pkg;
	// phase of a character, shared by transmitter and receiver
	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_START = 2'h1,
		PH_DATA = 2'h2,
		PH_STOP = 2'h3
	} phase_t;
	// registered pin drive
	typedef struct packed {
		logic txd;
		logic ir_n;
		logic rts_n;
		logic dtr_n;
		logic aux_a_n;
		logic aux_b_n;
	} pins_t;
	// whole state of the block
	typedef struct packed {
		logic [15:0] ctl;
		logic tst;
		logic [15:0] rdata;
		logic [1:0][7:0] txb;
		logic [1:0] tx_cnt;
		logic tx_in_ready;
		phase_t tx_ph;
		logic [15:0] tx_div;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_line;
		phase_t rx_ph;
		logic [15:0] rx_div;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic [1:0][7:0] rxb;
		logic [1:0] rx_cnt;
		logic rx_out_valid;
		pins_t pins;
	} state_t;
endpackage : port_ctl_pkg

/* verif/uart_remote_model.sv */
// remote terminal on the serial lines: sends and checks 8N1 characters
// assumes the line is sampled on sys_clk with a bit time of BIT cycles
`timescale 1ns/1ps
module uart_remote_model #(
	parameter int BIT = 4
) (
	// clock
	input wire logic sys_clk,
	// serial lines
	input wire logic serial_tx_pin,
	output logic serial_rx_pin,
	// flow control
	output logic clear_to_send_pin_n
);
	// line idles high as if pulled up; clear-to-send starts asserted
	initial begin
		serial_rx_pin = 1'b1;
		clear_to_send_pin_n = 1'b0;
	end
	// one character, start bit, lsb first, stop bit
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			serial_rx_pin <= f[i];
			repeat (BIT) @(posedge sys_clk);
		end
	endtask : send
	// sample mid bit; bit 8 flags a timeout or a low stop bit
	task automatic recv(output logic [8:0] r);
		int n;
		n = 0;
		r = 9'h100;
		while (serial_tx_pin !== 1'b0 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 400) return;
		repeat (BIT / 2) @(posedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge sys_clk);
			if (i < 8) r[i] = serial_tx_pin;
			else r[8] = ~serial_tx_pin;
		end
	endtask : recv
endmodule : uart_remote_model

/* verif/uart_control_flow_loopback_tb.sv */
// self-checking bench for the port control block against a remote terminal
// assumes the register map of the constants header and a 4-cycle bit time
`timescale 1ns/1ps
`include "port_ctl_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module uart_control_flow_loopback_tb;
	// --------
	// signals
	// --------
	logic sys_clk, srst, wr_en, rd_en, tx_valid, rx_ready, tx_ready, rx_valid;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, v;
	logic [7:0] tx_data, rx_data;
	logic serial_tx_pin, serial_rx_pin, ir_n, cts_n, dsr_n, dcd_n, ri_n;
	logic rts_n, dtr_n, aux_a_n, aux_b_n;
	logic [8:0] got;
	int n_mismatch = 0;
	int cmp_count = 0;
	int mb[4] = '{11, 10, 12, 13}; // control bit looped to status bits 4..7
	// free-running clock, 10 ns
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// short bit time keeps each character near forty cycles
	uart_control_flow_loopback #(.BIT_CYCLES(16'h0004)) dut (
		.sys_clk(sys_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin),
		.ir_pulse_pin_n(ir_n), .ir_receive_pin(serial_rx_pin), .request_send_pin_n(rts_n),
		.terminal_ready_pin_n(dtr_n), .aux_output_a_pin_n(aux_a_n),
		.aux_output_b_pin_n(aux_b_n), .clear_to_send_pin_n(cts_n),
		.data_set_ready_pin_n(dsr_n), .carrier_detect_pin_n(dcd_n), .ring_pin_n(ri_n));
	uart_remote_model #(.BIT(4)) far_end (.sys_clk(sys_clk), .serial_tx_pin(serial_tx_pin),
		.serial_rx_pin(serial_rx_pin), .clear_to_send_pin_n(cts_n));
	// --------
	// access tasks
	// --------
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask : rd
	// offer one character until the buffer takes it
	task automatic push(input logic [7:0] d);
		@(posedge sys_clk);
		tx_valid <= 1'b1;
		tx_data <= d;
		for (int i = 0; i < 500; i++) begin
			@(posedge sys_clk);
			if (tx_ready === 1'b1) break;
		end
		tx_valid <= 1'b0;
		if (tx_ready !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] %0t push timed out", $time);
			test_done();
		end
	endtask : push
	// wait for a received character, check it, then take it with a one-cycle ready
	task automatic pull(input logic [7:0] e);
		for (int i = 0; i < 500; i++) begin
			@(posedge sys_clk);
			#1;
			if (rx_valid === 1'b1) break;
		end
		`CHK({rx_valid, rx_data}, {1'b1, e})
		@(posedge sys_clk);
		rx_ready <= 1'b1;
		@(posedge sys_clk);
		rx_ready <= 1'b0;
	endtask : pull
	// the plain serial line must stay idle for n cycles
	task automatic quiet(input int n);
		int lows;
		lows = 0;
		repeat (n) begin
			@(posedge sys_clk);
			if (serial_tx_pin !== 1'b1) lows++;
		end
		`CHK(lows, 0)
	endtask : quiet
	task automatic test_done();
		if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : test_done
	// --------
	// main sequence
	// --------
	initial begin
		srst = 1'b1;
		{wr_en, rd_en, tx_valid, addr, wdata, tx_data} = '0;
		// sink holds ready low; pull takes each character itself
		{rx_ready, dsr_n, dcd_n, ri_n} = 4'h7;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		rd(`PC_CTL_OFF, v);
		`CHK(v, `PC_CTL_RST)
		`CHK({aux_b_n, aux_a_n, rts_n, dtr_n, serial_tx_pin, ir_n}, 6'h3E)
		rd(4'hC, v);
		`CHK(v, 16'h0000)
		// each modem output alone, pins one cycle behind the register
		for (int i = 0; i < 4; i++) begin
			wr(`PC_CTL_OFF, 16'h0400 << i);
			@(posedge sys_clk);
			#1;
			`CHK({aux_b_n, aux_a_n, rts_n, dtr_n}, ~(4'h1 << i))
		end
		// modem loopback wins over active outside inputs
		@(posedge sys_clk);
		{dsr_n, dcd_n, ri_n} <= 3'h0;
		for (int i = 0; i < 4; i++) begin
			wr(`PC_CTL_OFF, 16'h0080 | (16'h0001 << mb[i]));
			rd(`PC_STA_OFF, v);
			`CHK(v[7:4], 4'h1 << i)
		end
		wr(`PC_CTL_OFF, 16'h0080);
		rd(`PC_STA_OFF, v);
		`CHK(v[7:4], 4'h0)
		// plain loopback, transmit path into receive path
		wr(`PC_CTL_OFF, 16'h0381);
		push(8'hA5);
		pull(8'hA5);
		// clear-to-send high but flow control off
		wr(`PC_CTL_OFF, 16'h0301);
		far_end.clear_to_send_pin_n <= 1'b1;
		fork
			push(8'h3C);
			far_end.recv(got);
		join
		`CHK(got, 9'h03C)
		// flow control on: hold until clear-to-send drops
		wr(`PC_CTL_OFF, 16'h8301);
		push(8'h5A);
		quiet(60);
		far_end.clear_to_send_pin_n <= 1'b0;
		far_end.recv(got);
		`CHK(got, 9'h05A)
		// port off blocks the transmitter until enabled
		wr(`PC_CTL_OFF, 16'h0300);
		push(8'h96);
		quiet(60);
		fork
			wr(`PC_CTL_OFF, 16'h0301);
			far_end.recv(got);
		join
		`CHK(got, 9'h096)
		// transmit section off mid character: the character still completes
		fork
			push(8'hC3);
			far_end.recv(got);
			begin
				repeat (20) @(posedge sys_clk);
				wr(`PC_CTL_OFF, 16'h0201);
			end
		join
		`CHK(got, 9'h0C3)
		push(8'hF0);
		quiet(60);
		fork
			wr(`PC_CTL_OFF, 16'h0301);
			far_end.recv(got);
		join
		`CHK(got, 9'h0F0)
		// receive section off mid character
		fork
			far_end.send(8'h69);
			begin
				repeat (15) @(posedge sys_clk);
				wr(`PC_CTL_OFF, 16'h0101);
			end
			pull(8'h69);
		join
		// request-to-send follows room in the receive buffer
		wr(`PC_CTL_OFF, 16'h4301);
		@(posedge sys_clk);
		#1;
		`CHK(rts_n, 1'b0)
		far_end.send(8'h11);
		far_end.send(8'h22);
		repeat (10) @(posedge sys_clk);
		`CHK(rts_n, 1'b1)
		pull(8'h11);
		pull(8'h22);
		// infrared loopback, plain line held at mark
		wr(`PC_TST_OFF, 16'h0004);
		rd(`PC_TST_OFF, v);
		`CHK(v, 16'h0004)
		wr(`PC_CTL_OFF, 16'h0383);
		fork
			begin
				push(8'h4B);
				pull(8'h4B);
			end
			quiet(60);
		join
		wr(`PC_TST_OFF, 16'h0000);
		rd(`PC_TST_OFF, v);
		`CHK(v, 16'h0000)
		// infrared receive line, loopback off
		wr(`PC_CTL_OFF, 16'h0303);
		fork
			far_end.send(8'h5C);
			pull(8'h5C);
		join
		// reset in mid-run restores the control value
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		rd(`PC_CTL_OFF, v);
		`CHK(v, `PC_CTL_RST)
		test_done();
	end
endmodule : uart_control_flow_loopback_tb
